/* core/dcs_bit_counter.sv */
`default_nettype none
module dcs_bit_counter
  import dcs_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  rst,
  input  wire logic  ce,
  input  wire logic  bitTick,
  input  wire logic  charCountNonZero,
  output logic       bitStateOne,
  output logic       bitStateSix
);
  logic [2:0] bitcntFf_q;
  logic [2:0] bitcntFf_d;
  logic       advance;

  assign advance = bitTick && ((bitcntFf_q != JOHNSON_ONE) || charCountNonZero);
  assign bitcntFf_d = advance ? {bitcntFf_q[1:0], ~bitcntFf_q[2]} : bitcntFf_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bitcntFf_q  <= JOHNSON_ONE;
      bitStateOne <= 1'b1;
      bitStateSix <= 1'b0;
    end
    else if (ce)
    begin
      bitcntFf_q  <= bitcntFf_d;
      bitStateOne <= (bitcntFf_d == JOHNSON_ONE);
      bitStateSix <= (bitcntFf_d == JOHNSON_SIX);
    end
  end
endmodule
`default_nettype wire

/* core/dcs_controller.sv */
`default_nettype none
module dcs_controller
  import dcs_pkg::*;
#(
  parameter int HOLD_COUNT = HOLD_CYCLES
)
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  dcs_link_if.device       link,
  input  wire logic        bitClock,
  input  wire logic        diskPulse,
  input  wire logic        readData,
  input  wire logic        readOp,
  input  wire logic        onCylinder,
  input  wire logic        sectorMatch,
  input  wire logic        charCountNonZero,
  input  wire logic        trackIdMatch,
  input  wire logic        lrccCompared,
  input  wire logic        trackCheckError,
  input  wire logic        statusReturnStep,
  input  wire logic        errorClear,
  input  wire logic [7:0]  cylinderNow,
  output logic [3:0]       tagSel,
  output logic [7:0]       fileBus,
  output logic             sectorSearch,
  output logic             sectorCompareResult,
  output logic             bitStateOne,
  output logic             bitStateSix,
  output logic [1:0]       readState,
  output logic             readTallyInc,
  output logic             missedClockCarry,
  output logic             badSectorFlag,
  output logic             readCheckError,
  output logic             selectedSync
);
  localparam int NPIN = 13;

  // Link domain: reset arrives from the mclk domain through two flops.
  logic [1:0]        linkRst_q;
  logic              linkStrobe_q;
  logic              selected_q;
  logic [DATA_W-1:0] word_q;
  logic              wordToggle_q;

  // The host stops the link clock while it is in reset, so the request is stretched past the release.
  localparam int RST_HOLD_W = 5;
  logic [RST_HOLD_W-1:0] rstHold_q;
  logic                  linkRstReq_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rstHold_q    <= '1;
      linkRstReq_q <= 1'b1;
    end
    else if (ce)
    begin
      if (rstHold_q != '0)
        rstHold_q <= rstHold_q - 1'b1;
      linkRstReq_q <= (rstHold_q != '0);
    end
  end

  always_ff @(posedge link.linkClk)
  begin
    linkRst_q <= {linkRst_q[0], linkRstReq_q};
  end

  always_ff @(posedge link.linkClk)
  begin
    if (linkRst_q[1])
      selected_q <= 1'b0;
    else if (linkStrobe_q && !link.hostStrobe && link.facilitySelect
             && link.hostData[7:0] == DEVICE_ZERO)
      selected_q <= 1'b1;
  end

  always_ff @(posedge link.linkClk)
  begin
    if (linkRst_q[1])
    begin
      linkStrobe_q <= 1'b0;
      word_q       <= '0;
      wordToggle_q <= 1'b0;
    end
    else
    begin
      linkStrobe_q <= link.hostStrobe;
      if (selected_q && !linkStrobe_q && link.hostStrobe && !link.facilitySelect)
      begin
        word_q       <= link.hostData;
        wordToggle_q <= ~wordToggle_q;
      end
    end
  end

  // Pin and cross-domain inputs pass two flops; the second and a third copy feed edge detectors.
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] pinS1_q;
  logic [NPIN-1:0] pinS2_q;
  logic [NPIN-1:0] pinS3_q;
  assign pinRaw = {selected_q, wordToggle_q, bitClock, diskPulse, readData, readOp, onCylinder,
                   sectorMatch, charCountNonZero, trackIdMatch, lrccCompared, trackCheckError,
                   statusReturnStep};

  genvar g;
  generate
    for (g = 0; g < NPIN; g++)
    begin : gSync
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          pinS1_q[g] <= 1'b0;
          pinS2_q[g] <= 1'b0;
          pinS3_q[g] <= 1'b0;
        end
        else if (ce)
        begin
          pinS1_q[g] <= pinRaw[g];
          pinS2_q[g] <= pinS1_q[g];
          pinS3_q[g] <= pinS2_q[g];
        end
      end
    end
  endgenerate

  logic wordEvent;
  logic bitTick;
  logic pulseEdge;
  logic sData;
  logic sReadOp;
  logic sOnCyl;
  logic sSecMatch;
  logic sCharNz;
  logic sIdMatch;
  logic sLrcc;
  logic sTrkErr;
  logic sStatRt;
  // Toggles seen while the link side is still resetting are stale, so they are dropped.
  assign wordEvent = (pinS2_q[11] ^ pinS3_q[11]) && !linkRstReq_q;
  assign bitTick   = pinS2_q[10] && !pinS3_q[10];
  assign pulseEdge = pinS2_q[9] && !pinS3_q[9];
  assign sData     = pinS2_q[8];
  assign sReadOp   = pinS2_q[7];
  assign sOnCyl    = pinS2_q[6];
  assign sSecMatch = pinS2_q[5];
  assign sCharNz   = pinS2_q[4];
  assign sIdMatch  = pinS2_q[3];
  assign sLrcc     = pinS2_q[2];
  assign sTrkErr   = pinS2_q[1];
  assign sStatRt   = pinS2_q[0];

  // The word register is stable for many link periods after its toggle, so it is sampled directly.
  logic [7:0] diffAbs;
  assign diffAbs = (word_q[7:0] >= cylinderNow) ? word_q[7:0] - cylinderNow : cylinderNow - word_q[7:0];

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tagSel       <= '0;
      fileBus      <= '0;
      selectedSync <= 1'b0;
    end
    else if (ce)
    begin
      selectedSync <= pinS2_q[12];
      if (wordEvent)
      begin
        case (dcs_kind_t'(word_q[9:8]))
          KIND_CONTROL:
          begin
            tagSel  <= TAG_CONTROL;
            fileBus <= word_q[7:0];
          end
          KIND_CYLINDER:
          begin
            tagSel  <= TAG_CYLINDER;
            fileBus <= dcsMirror(word_q[7:0]);
          end
          KIND_HEAD:
          begin
            tagSel  <= TAG_HEAD;
            fileBus <= {word_q[7:4], 3'h0, word_q[0]};
          end
          KIND_DIFFERENCE:
          begin
            tagSel  <= TAG_DIFFERENCE;
            fileBus <= dcsMirror(~diffAbs);
          end
          default:
          begin
            tagSel  <= '0;
            fileBus <= '0;
          end
        endcase
      end
    end
  end

  // Sector search; the hold is counted so that a later match cannot shortcut it.
  logic                        deltaSearch_q;
  logic [$clog2(HOLD_COUNT+1)-1:0] hold_q;

  // Search after on-cylinder, 70 us hold.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sectorSearch        <= 1'b0;
      deltaSearch_q       <= 1'b0;
      sectorCompareResult <= 1'b0;
      hold_q              <= '0;
    end
    else if (ce)
    begin
      if (!sOnCyl)
      begin
        sectorSearch        <= 1'b0;
        deltaSearch_q       <= 1'b0;
        sectorCompareResult <= 1'b0;
        hold_q              <= '0;
      end
      else if (!sectorSearch && !deltaSearch_q && !sectorCompareResult)
        sectorSearch <= 1'b1;
      else if (sectorSearch && sSecMatch)
      begin
        sectorSearch  <= 1'b0;
        deltaSearch_q <= 1'b1;
        hold_q        <= '0;
      end
      else if (deltaSearch_q)
      begin
        if (hold_q == ($bits(hold_q))'(HOLD_COUNT - 1))
        begin
          deltaSearch_q       <= 1'b0;
          sectorCompareResult <= 1'b1;
        end
        else
          hold_q <= hold_q + 1'b1;
      end
    end
  end

  dcs_bit_counter uBitCounter (
    .mclk             (mclk),
    .rst              (rst),
    .ce               (ce),
    .bitTick          (bitTick),
    .charCountNonZero (sCharNz),
    .bitStateOne      (bitStateOne),
    .bitStateSix      (bitStateSix)
  );

  // Read state counter with leader and preamble run detectors.
  dcs_rdstate_t rd_q;
  logic [2:0]   zeroRun_q;
  logic [2:0]   oneRun_q;
  logic         trkErrSeen_q;
  assign readState = rd_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      zeroRun_q <= '0;
      oneRun_q  <= '0;
    end
    else if (ce)
    begin
      // Bits seen outside a read would otherwise count toward the leader run.
      if (!sReadOp)
      begin
        zeroRun_q <= '0;
        oneRun_q  <= '0;
      end
      else if (bitTick)
      begin
        zeroRun_q <= sData ? 3'h0 : (zeroRun_q == 3'(RUN_LEN) ? zeroRun_q : zeroRun_q + 3'h1);
        oneRun_q  <= !sData ? 3'h0 : (oneRun_q == 3'(RUN_LEN) ? oneRun_q : oneRun_q + 3'h1);
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rd_q         <= RD_S0;
      trkErrSeen_q <= 1'b0;
      readTallyInc <= 1'b0;
    end
    else if (ce)
    begin
      readTallyInc <= 1'b0;
      case (rd_q)
        RD_S0:
        begin
          if (sReadOp && zeroRun_q == 3'(RUN_LEN))
            rd_q <= RD_S1;
        end
        RD_S1:
        begin
          if (oneRun_q == 3'(RUN_LEN))
            rd_q <= RD_S2;
        end
        RD_S2:
        begin
          if (sIdMatch)
            rd_q <= RD_S3;
        end
        RD_S3:
        begin
          if (sTrkErr)
            trkErrSeen_q <= 1'b1;
          if ((trkErrSeen_q || sTrkErr) && sStatRt)
          begin
            readTallyInc <= 1'b1;
            trkErrSeen_q <= 1'b0;
            rd_q         <= RD_S0;
          end
          else if (!trkErrSeen_q && !sTrkErr && sLrcc)
            rd_q <= RD_S0;
        end
        default:
          rd_q <= RD_S0;
      endcase
      if (!sReadOp && rd_q != RD_S3)
        rd_q <= RD_S0;
    end
  end

  // Missing-clock timer and its modulus-16 counter.
  logic [$clog2(MISS_CYCLES+1)-1:0] gap_q;
  logic [MISS_W-1:0]                missCnt_q;
  logic                             missTimeout;
  assign missTimeout = sReadOp && !pulseEdge && gap_q == ($bits(gap_q))'(MISS_CYCLES);

  always_ff @(posedge mclk)
  begin
    if (rst)
      gap_q <= '0;
    else if (ce)
      gap_q <= (pulseEdge || missTimeout || !sReadOp) ? '0 : gap_q + 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      missCnt_q        <= '0;
      missedClockCarry <= 1'b0;
    end
    else if (ce)
    begin
      missedClockCarry <= missTimeout && (&missCnt_q);
      if (missTimeout)
        missCnt_q <= missCnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      badSectorFlag  <= 1'b0;
      readCheckError <= 1'b0;
    end
    else if (ce)
    begin
      badSectorFlag  <= missedClockCarry || (badSectorFlag && !errorClear);
      readCheckError <= missTimeout || (readCheckError && !errorClear);
    end
  end
endmodule
`default_nettype wire

/* core/dcs_host.sv */
`default_nettype none
module dcs_host
  import dcs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  dcs_link_if.host         link,
  input  wire logic        cmdValid,
  input  wire logic [1:0]  cmdKind,
  input  wire logic [7:0]  cmdByte,
  output logic             cmdReady
);
  logic [1:0]        div_q;
  logic              linkClk_q;
  logic              strobe_q;
  logic              fsel_q;
  logic [DATA_W-1:0] data_q;
  logic              selDone_q;
  logic [DATA_W-1:0] pend_q;
  dcs_hstate_t       hs_q;
  logic              linkFall;

  assign link.linkClk        = linkClk_q;
  assign link.hostStrobe     = strobe_q;
  assign link.facilitySelect = fsel_q;
  assign link.hostData       = data_q;
  // Link outputs change only with the link clock's fall, so the device sees them settled.
  assign linkFall = linkClk_q && div_q == 2'(LINK_HALF - 1);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      div_q     <= '0;
      linkClk_q <= 1'b0;
    end
    else if (ce)
    begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'(LINK_HALF - 1))
        linkClk_q <= ~linkClk_q;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      hs_q      <= HS_IDLE;
      strobe_q  <= 1'b0;
      fsel_q    <= 1'b0;
      data_q    <= '0;
      selDone_q <= 1'b0;
      pend_q    <= '0;
      cmdReady  <= 1'b0;
    end
    else if (ce)
    begin
      cmdReady <= 1'b0;
      case (hs_q)
        HS_IDLE:
        begin
          // Ready toggles whatever valid does, so a waiting request always meets a ready edge.
          cmdReady <= !cmdReady;
          if (cmdValid && cmdReady)
          begin
            pend_q <= {cmdKind, cmdByte};
            hs_q   <= selDone_q ? HS_DATHI : HS_SELHI;
          end
        end
        HS_SELHI:
        begin
          if (linkFall)
          begin
            strobe_q <= 1'b1;
            fsel_q   <= 1'b1;
            data_q   <= {2'h0, DEVICE_ZERO};
            hs_q     <= HS_SELLO;
          end
        end
        HS_SELLO:
        begin
          if (linkFall)
          begin
            strobe_q  <= 1'b0;
            selDone_q <= 1'b1;
            hs_q      <= HS_DATHI;
          end
        end
        HS_DATHI:
        begin
          if (linkFall)
          begin
            strobe_q <= 1'b1;
            fsel_q   <= 1'b0;
            data_q   <= pend_q;
            hs_q     <= HS_DATLO;
          end
        end
        HS_DATLO:
        begin
          if (linkFall)
          begin
            strobe_q <= 1'b0;
            hs_q     <= HS_IDLE;
          end
        end
        default:
          hs_q <= HS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* core/dcs_link_if.sv */
`default_nettype none
interface dcs_link_if;
  import dcs_pkg::*;
  logic                linkClk;
  logic                hostStrobe;
  logic                facilitySelect;
  logic [DATA_W-1:0]   hostData;
  modport host (output linkClk, output hostStrobe, output facilitySelect, output hostData);
  modport device (input linkClk, input hostStrobe, input facilitySelect, input hostData);
endinterface
`default_nettype wire

/* core/dcs_pkg.sv */
// What this block does
// - At most one drive tag line active.
// - Active tag sets meaning of file bus.
// - Control tag bits: write, read, seek, etc.
// - Cylinder tag: bit 0 weighs 128.
// - Head tag: bit 0 forward, bits 4-7 head.
// - Difference tag carries one's complement value.
// - Sector search after on-cylinder; hold 70 us.
// - Bit counter: three-stage Johnson, six states.
// - Bit counter advances unless resting, chars zero.
// - Bit counter rests in state one.
// - Read state counter: two bits, states 0-3.
// - Six leader zeros move state 0 to 1.
// - Six preamble ones move state 1 to 2.
// - Identifier match enters 3 until check compared.
// - Track error holds 3 through status return.
// - Missed-clock counter modulus 16, carry only.
// - Missed-clock carry sets bad-sector flag.
// - Strobe ignored until selected, then synchronised.
// - Strobe fall with select, device zero selects.
// - Over 1.0 us between pulses: missed clock.
`default_nettype none
package dcs_pkg;
  localparam int CLK_NS = 8;
  localparam int MISS_NS = 1000;
  localparam int MISS_CYCLES = MISS_NS / CLK_NS;
  localparam int HOLD_US = 70;
  localparam int HOLD_CYCLES = HOLD_US * 1000 / CLK_NS;
  localparam int LINK_HALF = 4;
  localparam int DATA_W = 10;
  localparam int RUN_LEN = 6;
  localparam int MISS_W = 4;
  localparam logic [7:0] DEVICE_ZERO = 8'h00;
  localparam logic [2:0] JOHNSON_ONE = 3'h0;
  localparam logic [2:0] JOHNSON_SIX = 3'h4;
  typedef enum logic [1:0] {KIND_CONTROL, KIND_CYLINDER, KIND_HEAD, KIND_DIFFERENCE} dcs_kind_t;
  typedef enum logic [1:0] {RD_S0, RD_S1, RD_S2, RD_S3} dcs_rdstate_t;
  typedef enum logic [2:0] {HS_IDLE, HS_SELHI, HS_SELLO, HS_DATHI, HS_DATLO} dcs_hstate_t;
  localparam logic [3:0] TAG_CONTROL = 4'h1;
  localparam logic [3:0] TAG_CYLINDER = 4'h2;
  localparam logic [3:0] TAG_HEAD = 4'h4;
  localparam logic [3:0] TAG_DIFFERENCE = 4'h8;

  // File bus bit 0 carries the heaviest weight, so binary values are mirrored.
  function automatic logic [7:0] dcsMirror(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction
endpackage
`default_nettype wire

/* testbench/dcs_seq_properties.sv */
`default_nettype none
module dcs_seq_properties
  import dcs_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              linkClk,
  input  wire logic              hostStrobe,
  input  wire logic              facilitySelect,
  input  wire logic [DATA_W-1:0] hostData,
  input  wire logic [3:0]        tagSel,
  input  wire logic [1:0]        readState,
  input  wire logic              bitStateOne,
  input  wire logic              bitStateSix,
  input  wire logic              missedClockCarry,
  input  wire logic              badSectorFlag,
  input  wire logic              sectorSearch,
  input  wire logic              sectorCompareResult
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  tag_one_hot_a: assert property ($onehot0(tagSel))
    else $error("more than one tag line active");
  select_dev_zero_a: assert property ($fell(hostStrobe) && facilitySelect |-> hostData[7:0] == DEVICE_ZERO)
    else $error("selection strobe without device zero");
  strobe_width_a: assert property ($rose(hostStrobe) |-> hostStrobe [*8])
    else $error("host strobe shorter than one link period");
  johnson_decode_a: assert property (!(bitStateOne && bitStateSix))
    else $error("bit counter decodes two states");
  read_step_a: assert property (readState != $past(readState) |->
    readState == $past(readState) + 2'h1 || readState == 2'h0)
    else $error("read state skipped a step");
  search_hold_a: assert property ($fell(sectorSearch) |-> !sectorCompareResult [*8])
    else $error("compare result not held off after match");
  carry_flag_a: assert property (missedClockCarry |=> badSectorFlag)
    else $error("carry did not set bad sector flag");
  flag_cause_a: assert property ($rose(badSectorFlag) |-> $past(missedClockCarry))
    else $error("bad sector flag set without carry");
  six_to_one_a: assert property ($fell(bitStateSix) |-> bitStateOne)
    else $error("bit counter left state six other than to state one");
  link_settled_a: assert property ($rose(linkClk) |->
    $stable(hostStrobe) && $stable(facilitySelect) && $stable(hostData))
    else $error("link lines changed at the link clock rise");
endmodule
`default_nettype wire

/* testbench/tb_disc_controller_sequencing.sv */
`default_nettype none
module tb_disc_controller_sequencing
  import dcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  logic        mclk, rst, cmdValid, cmdReady, bitClock, diskPulse, readData, readOp, onCylinder;
  logic        sectorMatch, charCountNonZero, trackIdMatch, lrccCompared, trackCheckError, statusReturnStep;
  logic        sectorSearch, sectorCompareResult, bitStateOne, bitStateSix, readTallyInc;
  logic        missedClockCarry, badSectorFlag, readCheckError, selectedSync;
  logic [1:0]  cmdKind, readState, rdQ[$];
  logic [7:0]  cmdByte, cylinderNow, fileBus;
  logic [3:0]  tagSel;
  logic [11:0] lastOut, linkQ[$];
  logic [1:0]  lastRd;
  logic [31:0] seed;
  int          error_cnt, num_checks, tallyCnt, n;

  dcs_link_if lnk();
  dcs_host u_dcs_host (.mclk(mclk), .rst(rst), .ce(1'b1), .link(lnk), .cmdValid(cmdValid),
    .cmdKind(cmdKind), .cmdByte(cmdByte), .cmdReady(cmdReady));
  dcs_controller #(.HOLD_COUNT(HOLD)) u_dcs_controller (.mclk(mclk), .rst(rst), .ce(1'b1), .link(lnk),
    .bitClock(bitClock), .diskPulse(diskPulse), .readData(readData), .readOp(readOp),
    .onCylinder(onCylinder), .sectorMatch(sectorMatch), .charCountNonZero(charCountNonZero),
    .trackIdMatch(trackIdMatch), .lrccCompared(lrccCompared), .trackCheckError(trackCheckError),
    .statusReturnStep(statusReturnStep), .errorClear(1'b0), .cylinderNow(cylinderNow), .tagSel(tagSel),
    .fileBus(fileBus), .sectorSearch(sectorSearch), .sectorCompareResult(sectorCompareResult),
    .bitStateOne(bitStateOne), .bitStateSix(bitStateSix), .readState(readState),
    .readTallyInc(readTallyInc), .missedClockCarry(missedClockCarry), .badSectorFlag(badSectorFlag),
    .readCheckError(readCheckError), .selectedSync(selectedSync));
  dcs_seq_properties u_chk (.mclk(mclk), .rst(rst), .linkClk(lnk.linkClk), .hostStrobe(lnk.hostStrobe),
    .facilitySelect(lnk.facilitySelect), .hostData(lnk.hostData), .tagSel(tagSel), .readState(readState),
    .bitStateOne(bitStateOne), .bitStateSix(bitStateSix), .missedClockCarry(missedClockCarry),
    .badSectorFlag(badSectorFlag), .sectorSearch(sectorSearch), .sectorCompareResult(sectorCompareResult));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  // The request stays up until an edge that samples cmdReady high.
  task automatic send(input logic [1:0] kind, input logic [7:0] b);
    int k;
    k = 0;
    cmdKind = kind;
    cmdByte = b;
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1 && k < 2000)
    begin
      cyc(1);
      k++;
    end
    if (k >= 2000)
    begin
      error_cnt++;
      $display("[ERR] cmdReady expected 1 seen timeout");
    end
    cyc(1);
    cmdValid = 1'b0;
    cyc(1);
  endtask

  task automatic runCmds(input int cnt);
    logic [7:0] b;
    logic [7:0] e;
    logic [7:0] d;
    for (int k = 0; k < cnt; k++)
    begin
      seed = lfsr(seed);
      b = seed[7:0];
      d = (b > cylinderNow) ? b - cylinderNow : cylinderNow - b;
      case (k % 4)
        0: e = b;
        1: e = rev8(b);
        2: e = {b[7:4], 3'h0, b[0]};
        default: e = rev8(~d);
      endcase
      linkQ.push_back({4'h1 << (k % 4), e});
      send(2'(k % 4), b);
    end
    cyc(120);
    chk("pending link words", 16'h0, 16'(linkQ.size()));
    chk("selectedSync", 16'h1, 16'(selectedSync));
  endtask

  task automatic bitTick(input logic d);
    readData = d;
    bitClock = 1'b1;
    diskPulse = 1'b1;
    cyc(4);
    bitClock = 1'b0;
    diskPulse = 1'b0;
    cyc(4);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(8);
    s = 1'b0;
    cyc(8);
  endtask

  // Sampled on the falling edge so that outputs launched at the rising edge have settled.
  always @(negedge mclk)
  begin
    if (rst)
    begin
      lastOut = '0;
      lastRd = 2'h0;
    end
    else
    begin
      if (readTallyInc === 1'b1)
        tallyCnt++;
      if ({tagSel, fileBus} !== lastOut)
      begin
        lastOut = {tagSel, fileBus};
        chk("tagSel fileBus", 16'(linkQ.size() > 0 ? linkQ.pop_front() : 12'h0), 16'(lastOut));
      end
      if (readState !== lastRd)
      begin
        lastRd = readState;
        chk("readState", 16'(rdQ.size() > 0 ? rdQ.pop_front() : 2'h0), 16'(lastRd));
      end
    end
  end

  initial
  begin
    #200us;
    error_cnt++;
    $display("[ERR] watchdog expected done seen hang");
    test_done();
  end

  initial
  begin
    {cmdValid, bitClock, diskPulse, readData, readOp, onCylinder, sectorMatch} = '0;
    {charCountNonZero, trackIdMatch, lrccCompared, trackCheckError, statusReturnStep} = '0;
    cmdKind = 2'h0;
    cmdByte = 8'h00;
    seed = 32'h67abc658;
    cylinderNow = seed[15:8];
    rst = 1'b1;
    cyc(16);
    rst = 1'b0;
    cyc(80);
    chk("selectedSync", 16'h0, 16'(selectedSync));
    runCmds(8);
    onCylinder = 1'b1;
    cyc(8);
    chk("sectorSearch", 16'h1, 16'(sectorSearch));
    sectorMatch = 1'b1;
    cyc(4);
    sectorMatch = 1'b0;
    n = 4;
    while (sectorCompareResult !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    chk("hold window", 16'h1, 16'(n >= HOLD && n <= HOLD + 12));
    onCylinder = 1'b0;
    readOp = 1'b1;
    // The errored pass runs first so the tally count is checked before the clean pass.
    for (int err = 1; err >= 0; err--)
    begin
      rdQ = {rdQ, 2'h1, 2'h2, 2'h3, 2'h0};
      repeat (6) bitTick(1'b0);
      repeat (6) bitTick(1'b1);
      pulse(trackIdMatch);
      trackCheckError = err[0];
      pulse(lrccCompared);
      if (err == 1)
      begin
        chk("readState held", 16'h3, 16'(readState));
        pulse(statusReturnStep);
      end
      trackCheckError = 1'b0;
      chk("tally pulses", 16'h1, 16'(tallyCnt));
    end
    readOp = 1'b0;
    charCountNonZero = 1'b1;
    repeat (5) bitTick(1'b0);
    chk("bitStateSix", 16'h1, 16'(bitStateSix));
    charCountNonZero = 1'b0;
    bitTick(1'b0);
    bitTick(1'b0);
    chk("bitStateOne", 16'h1, 16'(bitStateOne));
    readOp = 1'b1;
    repeat (10)
    begin
      diskPulse = 1'b1;
      cyc(32);
      diskPulse = 1'b0;
      cyc(32);
    end
    chk("readCheckError", 16'h0, 16'(readCheckError));
    cyc(100);
    chk("readCheckError", 16'h1, 16'(readCheckError));
    cyc(1780);
    chk("badSectorFlag", 16'h0, 16'(badSectorFlag));
    cyc(120);
    chk("badSectorFlag", 16'h1, 16'(badSectorFlag));
    rdQ.push_back(2'h1);
    repeat (6) bitTick(1'b0);
    charCountNonZero = 1'b1;
    repeat (2) bitTick(1'b0);
    rst = 1'b1;
    cyc(4);
    chk("reset readState", 16'h0, 16'(readState));
    chk("reset bitStateOne", 16'h1, 16'(bitStateOne));
    chk("reset badSectorFlag", 16'h0, 16'(badSectorFlag));
    {readOp, charCountNonZero} = '0;
    rst = 1'b0;
    cyc(80);
    runCmds(4);
    test_done();
  end
endmodule
`default_nettype wire
